/* File: src/rca_block.sv */
// rtc control, constant-period and alarm logic with its registers
// What this block does
// - gate bit 7 of peripheral enable holds rtc in reset, blocks control writes
// - gate off makes control reads return defaults; supply mode reads normally
// - clock select 0 picks subsystem clock, 1 the low-speed oscillator
// - calendar counts only on subsystem clock; low-speed gives period interrupt only
// - on low-speed clock period interval scales by ratio of clock rates
// - counts year, month, weekday, day, hour, minute, second; years up to 99
// - run bit 0 stops counters, 1 starts them
// - 1 Hz pin output when enabled, never while run bit is 0
// - hour format 0 gives 12-hour with am/pm, 1 gives 24-hour
// - format changed under counter wait; hour value follows new format
// - three-bit field picks none, half second, second, minute, hour, day, month
// - alarm enable 0 disables matching, 1 enables it
// - alarm interrupt enable lets an alarm match raise the rtc interrupt
// - rtc interrupt serves as stop wakeup and converter snooze trigger
// - alarm flag sets one count cycle after match; write 0 clears it
// - period flag sets on each period event; write 0 clears it
// - counter wait stops calendar; wait status reads 1 within one count cycle
// - period and alarm events share one interrupt output
`timescale 1ns/100ps
`default_nettype none
module rca_block (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [19:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic sub_clk_pin,
	input wire logic lsosc_clk_pin,
	input wire logic [5:0] alarm_minute,
	input wire logic [4:0] alarm_hour,
	input wire logic [6:0] alarm_weekday,
	output logic one_hz_pin,
	output logic rtc_interrupt,
	output logic [7:0] hour_value
);
	// ---------------------------------------------------------------
	// registers and decode
	// ---------------------------------------------------------------
	logic [7:0] pcg0_r;
	logic [7:0] ssm_r;
	logic [7:0] ctl0_r;
	logic alarm_match_enable_r, alarm_irq_enable_r, counter_wait_r;
	logic alarm_status_flag_r, period_status_flag_r, wait_status_r;
	logic gate, tick, wr_ctl0, wr_ctl1, alarm_set, period_set;
	logic [7:0] rd_nxt;

	assign gate = pcg0_r[rca_pkg::B_GATE];
	assign wr_ctl0 = sfr_wr && gate && sfr_addr == rca_pkg::ADDR_CTL0;
	assign wr_ctl1 = sfr_wr && gate && sfr_addr == rca_pkg::ADDR_CTL1;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pcg0_r <= rca_pkg::RST_PCG0;
			ssm_r <= rca_pkg::RST_SSM;
		end else if (sfr_wr) begin
			if (sfr_addr == rca_pkg::ADDR_PCG0)
				pcg0_r <= sfr_wdata;
			else if (sfr_addr == rca_pkg::ADDR_SSM)
				ssm_r <= sfr_wdata & 8'h90;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			ctl0_r <= rca_pkg::RST_CTL0;
		else if (!gate)
			ctl0_r <= rca_pkg::RST_CTL0;
		else if (wr_ctl0)
			ctl0_r <= sfr_wdata & 8'hAF;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			alarm_match_enable_r <= 1'b0;
			alarm_irq_enable_r <= 1'b0;
			counter_wait_r <= 1'b0;
		end else if (!gate) begin
			alarm_match_enable_r <= 1'b0;
			alarm_irq_enable_r <= 1'b0;
			counter_wait_r <= 1'b0;
		end else if (wr_ctl1) begin
			alarm_match_enable_r <= sfr_wdata[rca_pkg::B_ALE];
			alarm_irq_enable_r <= sfr_wdata[rca_pkg::B_AIE];
			counter_wait_r <= sfr_wdata[rca_pkg::B_WAIT];
		end
	end

	// hardware set wins over a clearing write in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			alarm_status_flag_r <= 1'b0;
			period_status_flag_r <= 1'b0;
		end else if (!gate) begin
			alarm_status_flag_r <= 1'b0;
			period_status_flag_r <= 1'b0;
		end else begin
			if (alarm_set)
				alarm_status_flag_r <= 1'b1;
			else if (wr_ctl1 && !sfr_wdata[rca_pkg::B_AFLG])
				alarm_status_flag_r <= 1'b0;
			if (period_set)
				period_status_flag_r <= 1'b1;
			else if (wr_ctl1 && !sfr_wdata[rca_pkg::B_PFLG])
				period_status_flag_r <= 1'b0;
		end
	end

	always_comb begin
		rd_nxt = 8'h00;
		if (sfr_addr == rca_pkg::ADDR_PCG0)
			rd_nxt = pcg0_r;
		else if (sfr_addr == rca_pkg::ADDR_SSM)
			rd_nxt = ssm_r;
		else if (sfr_addr == rca_pkg::ADDR_CTL0)
			rd_nxt = gate ? ctl0_r : rca_pkg::RST_CTL0;
		else if (sfr_addr == rca_pkg::ADDR_CTL1)
			rd_nxt = gate ? {alarm_match_enable_r, alarm_irq_enable_r, 1'b0,
				alarm_status_flag_r, period_status_flag_r, 1'b0, wait_status_r,
				counter_wait_r} : rca_pkg::RST_CTL1;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			sfr_rdata <= 8'h00;
		else
			sfr_rdata <= rd_nxt;
	end

	// ---------------------------------------------------------------
	// count clock and control taken at count clock edges
	// ---------------------------------------------------------------
	logic run_cc_r, oe_cc_r, wait_cc_r, lsel_cc_r;
	logic [2:0] psel_cc_r;

	rca_tick_gen u_tick (
		.clk(clk),
		.arst_n(arst_n),
		.sub_clk_pin(sub_clk_pin),
		.lsosc_clk_pin(lsosc_clk_pin),
		.sel_lsosc(ssm_r[rca_pkg::B_CSEL]),
		.tick(tick)
	);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_cc_r <= 1'b0;
			oe_cc_r <= 1'b0;
			wait_cc_r <= 1'b0;
			lsel_cc_r <= 1'b0;
			psel_cc_r <= 3'h0;
		end else if (!gate) begin
			run_cc_r <= 1'b0;
			oe_cc_r <= 1'b0;
			wait_cc_r <= 1'b0;
			lsel_cc_r <= 1'b0;
			psel_cc_r <= 3'h0;
		end else if (tick) begin
			run_cc_r <= ctl0_r[rca_pkg::B_RUN];
			oe_cc_r <= ctl0_r[rca_pkg::B_OE];
			wait_cc_r <= counter_wait_r;
			lsel_cc_r <= ssm_r[rca_pkg::B_CSEL];
			psel_cc_r <= ctl0_r[rca_pkg::B_PSEL +: 3];
		end
	end

	// wait status drops at once when wait is cleared, sets on next count edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			wait_status_r <= 1'b0;
		else if (!gate || !counter_wait_r)
			wait_status_r <= 1'b0;
		else if (tick)
			wait_status_r <= 1'b1;
	end

	// ---------------------------------------------------------------
	// prescaler, calendar stepping
	// ---------------------------------------------------------------
	logic [rca_pkg::PRESC_W-1:0] presc_r;
	logic sec_evt, half_evt, sec_pend_r, step;
	logic [5:0] c_sec, c_min;
	logic [4:0] c_hour, c_day;
	logic [2:0] c_wday;
	logic [3:0] c_mon;
	logic [6:0] c_year;
	logic min_c, hour_c, day_c, mon_c;

	// same tick count on either source, so low-speed periods stretch by the rate ratio
	assign sec_evt = tick && run_cc_r && presc_r == rca_pkg::PRESC_SEC_LAST;
	assign half_evt = tick && run_cc_r && presc_r[13:0] == rca_pkg::PRESC_HALF_LAST;
	assign step = (sec_evt || sec_pend_r) && !wait_cc_r && !lsel_cc_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			presc_r <= '0;
		else if (!gate)
			presc_r <= '0;
		else if (tick && run_cc_r)
			presc_r <= presc_r + 15'h1;
	end

	// an overflow during wait is held and applied once wait ends
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			sec_pend_r <= 1'b0;
		else if (!gate || step || lsel_cc_r)
			sec_pend_r <= 1'b0;
		else if (sec_evt && wait_cc_r)
			sec_pend_r <= 1'b1;
	end

	rca_calendar u_cal (
		.clk(clk),
		.arst_n(arst_n),
		.clr(!gate),
		.step(step),
		.sec(c_sec),
		.minute(c_min),
		.hour(c_hour),
		.day(c_day),
		.wday(c_wday),
		.month(c_mon),
		.year(c_year),
		.min_carry(min_c),
		.hour_carry(hour_c),
		.day_carry(day_c),
		.mon_carry(mon_c)
	);

	// ---------------------------------------------------------------
	// constant period, alarm, interrupt, pin outputs
	// ---------------------------------------------------------------
	logic alarm_hit, alarm_prev_r, alarm_pend_r, period_evt;

	always_comb begin
		case (rca_pkg::rca_period_e'(psel_cc_r))
			rca_pkg::PER_NONE: period_evt = 1'b0;
			rca_pkg::PER_HALF: period_evt = half_evt;
			rca_pkg::PER_SEC: period_evt = sec_evt;
			rca_pkg::PER_MIN: period_evt = min_c;
			rca_pkg::PER_HOUR: period_evt = hour_c;
			rca_pkg::PER_DAY: period_evt = day_c;
			default: period_evt = mon_c;
		endcase
	end
	assign period_set = period_evt;

	assign alarm_hit = alarm_match_enable_r && c_min == alarm_minute && c_hour == alarm_hour
		&& alarm_weekday[c_wday];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			alarm_prev_r <= 1'b0;
			alarm_pend_r <= 1'b0;
		end else if (!gate) begin
			alarm_prev_r <= 1'b0;
			alarm_pend_r <= 1'b0;
		end else begin
			alarm_prev_r <= alarm_hit;
			if (alarm_hit && !alarm_prev_r)
				alarm_pend_r <= 1'b1;
			else if (tick)
				alarm_pend_r <= 1'b0;
		end
	end
	assign alarm_set = alarm_pend_r && tick;

	// one shared pulse; wakeup and snooze logic take it as is
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rtc_interrupt <= 1'b0;
		else
			rtc_interrupt <= period_set || (alarm_set && alarm_irq_enable_r);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			one_hz_pin <= 1'b0;
		else
			one_hz_pin <= run_cc_r && oe_cc_r && presc_r[14];
	end

	function automatic logic [7:0] to_bcd(input logic [4:0] v);
		logic [4:0] t;
		t = (v >= 5'd20) ? 5'd2 : (v >= 5'd10) ? 5'd1 : 5'd0;
		return {t[3:0], 4'(v - 5'(t * 5'd10))};
	endfunction

	// stored hour is 24-hour, so a format change converts at once
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			hour_value <= 8'h12;
		else if (ctl0_r[rca_pkg::B_HFMT])
			hour_value <= to_bcd(c_hour);
		else if (c_hour == 5'd0)
			hour_value <= 8'h12;
		else if (c_hour < 5'd12)
			hour_value <= to_bcd(c_hour);
		else if (c_hour == 5'd12)
			hour_value <= 8'h32;
		else
			hour_value <= to_bcd(c_hour - 5'd12) | 8'h20;
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_gate_blocks_wr: assert property (@(posedge clk) disable iff (!arst_n)
		(!gate && sfr_wr && sfr_addr == rca_pkg::ADDR_CTL0) |=> ctl0_r == 8'h00)
		else $error("control write landed while gate off");
	chk_gate_read_def: assert property (@(posedge clk) disable iff (!arst_n)
		(!gate && sfr_addr == rca_pkg::ADDR_CTL1) |=> sfr_rdata == 8'h00)
		else $error("control read not default while gate off");
	chk_no_hz_stopped: assert property (@(posedge clk) disable iff (!arst_n)
		!run_cc_r |=> !one_hz_pin)
		else $error("1 Hz output while stopped");
	chk_stop_holds: assert property (@(posedge clk) disable iff (!arst_n)
		(!run_cc_r && !sec_pend_r) |=> $stable(c_sec))
		else $error("seconds moved while stopped");
	chk_lsel_no_cal: assert property (@(posedge clk) disable iff (!arst_n)
		lsel_cc_r |=> $stable(c_sec))
		else $error("calendar counted on low-speed clock");
	chk_wait_status: assert property (@(posedge clk) disable iff (!arst_n)
		(gate && counter_wait_r && tick) |=> wait_status_r)
		else $error("wait status late");
	chk_alarm_flag: assert property (@(posedge clk) disable iff (!arst_n)
		(gate && alarm_pend_r && tick) |=> alarm_status_flag_r)
		else $error("alarm flag not set");
	chk_period_irq: assert property (@(posedge clk) disable iff (!arst_n)
		(gate && period_evt) |=> rtc_interrupt && period_status_flag_r)
		else $error("period event lost");
	chk_alarm_mask: assert property (@(posedge clk) disable iff (!arst_n)
		(!period_evt && !alarm_irq_enable_r) |=> !rtc_interrupt)
		else $error("alarm interrupt while disabled");
	chk_hour_24: assert property (@(posedge clk) disable iff (!arst_n)
		(ctl0_r[rca_pkg::B_HFMT] && c_hour == 5'd13) |=> hour_value == 8'h13)
		else $error("24-hour value wrong");
endmodule // rca_block
`default_nettype wire

/* File: src/rca_pkg.sv */
// shared constants of the rtc control and alarm block
package rca_pkg;
	// ---------------------------------------------------------------
	// register addresses
	// ---------------------------------------------------------------
	localparam logic [19:0] ADDR_PCG0 = 20'hF00F0;
	localparam logic [19:0] ADDR_SSM = 20'hF00F3;
	localparam logic [19:0] ADDR_CTL0 = 20'hFFF9D;
	localparam logic [19:0] ADDR_CTL1 = 20'hFFF9E;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_PCG0 = 8'h00;
	localparam logic [7:0] RST_SSM = 8'h00;
	localparam logic [7:0] RST_CTL0 = 8'h00;
	localparam logic [7:0] RST_CTL1 = 8'h00;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int B_GATE = 7;
	localparam int B_LPSC = 7;
	localparam int B_CSEL = 4;
	localparam int B_RUN = 7;
	localparam int B_OE = 5;
	localparam int B_HFMT = 3;
	localparam int B_PSEL = 0;
	localparam int B_ALE = 7;
	localparam int B_AIE = 6;
	localparam int B_AFLG = 4;
	localparam int B_PFLG = 3;
	localparam int B_WST = 1;
	localparam int B_WAIT = 0;
	// ---------------------------------------------------------------
	// timing: count clock ticks per second and per half second
	// ---------------------------------------------------------------
	localparam int PRESC_W = 15;
	localparam logic [14:0] PRESC_SEC_LAST = 15'h7FFF;
	localparam logic [13:0] PRESC_HALF_LAST = 14'h3FFF;
	localparam int YEAR_MAX = 99;
	typedef enum logic [2:0] {
		PER_NONE = 3'b000,
		PER_HALF = 3'b001,
		PER_SEC = 3'b010,
		PER_MIN = 3'b011,
		PER_HOUR = 3'b100,
		PER_DAY = 3'b101,
		PER_MON0 = 3'b110,
		PER_MON1 = 3'b111
	} rca_period_e;
endpackage

/* File: src/rca_tick_gen.sv */
// count clock source selection and tick extraction
`timescale 1ns/100ps
`default_nettype none
module rca_tick_gen (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sub_clk_pin,
	input wire logic lsosc_clk_pin,
	input wire logic sel_lsosc,
	output logic tick
);
	logic [1:0] sub_s_r;
	logic [1:0] ls_s_r;
	logic mux_prev_r;
	logic mux_now;

	// two stages per pin before anything looks at it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sub_s_r <= 2'h0;
			ls_s_r <= 2'h0;
		end else begin
			sub_s_r <= {sub_s_r[0], sub_clk_pin};
			ls_s_r <= {ls_s_r[0], lsosc_clk_pin};
		end
	end

	assign mux_now = sel_lsosc ? ls_s_r[1] : sub_s_r[1];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mux_prev_r <= 1'b0;
			tick <= 1'b0;
		end else begin
			mux_prev_r <= mux_now;
			tick <= mux_now & ~mux_prev_r;
		end
	end
endmodule // rca_tick_gen
`default_nettype wire

/* File: src/rca_calendar.sv */
// second to year calendar counters, binary, 24-hour internal
`timescale 1ns/100ps
`default_nettype none
module rca_calendar (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clr,
	input wire logic step,
	output logic [5:0] sec,
	output logic [5:0] minute,
	output logic [4:0] hour,
	output logic [4:0] day,
	output logic [2:0] wday,
	output logic [3:0] month,
	output logic [6:0] year,
	output logic min_carry,
	output logic hour_carry,
	output logic day_carry,
	output logic mon_carry
);
	function automatic logic [4:0] days_in(input logic [3:0] m, input logic [6:0] y);
		logic [4:0] d;
		d = 5'd31;
		if (m == 4'd4 || m == 4'd6 || m == 4'd9 || m == 4'd11)
			d = 5'd30;
		else if (m == 4'd2)
			d = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
		return d;
	endfunction

	assign min_carry = step && sec == 6'd59;
	assign hour_carry = min_carry && minute == 6'd59;
	assign day_carry = hour_carry && hour == 5'd23;
	assign mon_carry = day_carry && day == days_in(month, year);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sec <= 6'h0;
			minute <= 6'h0;
			hour <= 5'h0;
			day <= 5'h1;
			wday <= 3'h0;
			month <= 4'h1;
			year <= 7'h0;
		end else if (clr) begin
			sec <= 6'h0;
			minute <= 6'h0;
			hour <= 5'h0;
			day <= 5'h1;
			wday <= 3'h0;
			month <= 4'h1;
			year <= 7'h0;
		end else if (step) begin
			sec <= min_carry ? 6'h0 : sec + 6'h1;
			if (min_carry)
				minute <= hour_carry ? 6'h0 : minute + 6'h1;
			if (hour_carry)
				hour <= day_carry ? 5'h0 : hour + 5'h1;
			if (day_carry) begin
				day <= mon_carry ? 5'h1 : day + 5'h1;
				wday <= (wday == 3'd6) ? 3'h0 : wday + 3'h1;
			end
			if (mon_carry) begin
				month <= (month == 4'd12) ? 4'h1 : month + 4'h1;
				if (month == 4'd12)
					year <= (year == 7'(rca_pkg::YEAR_MAX)) ? 7'h0 : year + 7'h1;
			end
		end
	end
endmodule // rca_calendar
`default_nettype wire

/* File: testbench/rca_block_tb_top.sv */
// self-checking bench of the rtc control and alarm block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) check(nm, e, g)
module rca_block_tb_top;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic clk;
	logic arst_n;
	logic [19:0] sfr_addr;
	logic sfr_wr;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic sub_clk_pin;
	logic lsosc_clk_pin;
	logic [5:0] alarm_minute;
	logic [4:0] alarm_hour;
	logic [6:0] alarm_weekday;
	logic one_hz_pin;
	logic rtc_interrupt;
	logic [7:0] hour_value;
	logic sub_on;
	logic ls_on;
	logic [31:0] seed;
	int fail_count;
	int total_checks;
	// source pins toggle every cycle: one tick per two cycles keeps a half second short
	localparam int TICK_CYC = 2;
	localparam int HALF_CYC = (int'(rca_pkg::PRESC_HALF_LAST) + 1) * TICK_CYC;
	localparam logic [19:0] A_PCG = rca_pkg::ADDR_PCG0;
	localparam logic [19:0] A_OSM = rca_pkg::ADDR_SSM;
	localparam logic [19:0] A_C0 = rca_pkg::ADDR_CTL0;
	localparam logic [19:0] A_C1 = rca_pkg::ADDR_CTL1;

	rca_block DUT (
		.clk(clk),
		.arst_n(arst_n),
		.sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata),
		.sub_clk_pin(sub_clk_pin),
		.lsosc_clk_pin(lsosc_clk_pin),
		.alarm_minute(alarm_minute),
		.alarm_hour(alarm_hour),
		.alarm_weekday(alarm_weekday),
		.one_hz_pin(one_hz_pin),
		.rtc_interrupt(rtc_interrupt),
		.hour_value(hour_value)
	);

	// ---------------------------------------------------------------
	// clocks
	// ---------------------------------------------------------------
	initial clk = 1'b0;
	always #2 clk = ~clk;
	// a stopped source stands still, so the unselected one cannot leak ticks
	always @(posedge clk) begin
		#1;
		if (sub_on) sub_clk_pin = ~sub_clk_pin;
		if (ls_on) lsosc_clk_pin = ~lsosc_clk_pin;
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// unused control bits read as zero
	function automatic logic [7:0] ctl0_exp(input logic [7:0] v);
		return v & 8'hAF;
	endfunction
	function automatic logic [7:0] ssm_exp(input logic [7:0] v);
		return v & 8'h90;
	endfunction
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk);
		#1;
		sfr_wr = 1'b0;
	endtask
	task automatic rdchk(input string nm, input logic [19:0] a, input logic [7:0] e);
		@(posedge clk);
		#1;
		sfr_addr = a;
		@(posedge clk);
		#1;
		`CHK(nm, e, sfr_rdata);
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	// interrupt is a one-cycle pulse, so every cycle is looked at
	task automatic wait_irq(input int mx, output int n);
		n = 0;
		while (rtc_interrupt !== 1'b1 && n < mx) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// watchdog
	// ---------------------------------------------------------------
	initial begin
		// two half-second waits dominate the run; keep well under the cycle budget
		repeat (2 * HALF_CYC + 20000) @(posedge clk);
		fail_count++;
		end_of_test();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic [7:0] v;
		int n;
		arst_n = 1'b0;
		sfr_addr = 20'h00000;
		sfr_wr = 1'b0;
		sfr_wdata = 8'h00;
		sub_clk_pin = 1'b0;
		lsosc_clk_pin = 1'b0;
		sub_on = 1'b0;
		ls_on = 1'b0;
		alarm_minute = 6'h05;
		alarm_hour = 5'h00;
		alarm_weekday = 7'h7F;
		seed = 32'h0000001E;
		fail_count = 0;
		total_checks = 0;
		repeat (5) @(posedge clk);
		#1;
		arst_n = 1'b1;
		`CHK("hour_rst", 8'h12, hour_value);
		rdchk("pcg0_rst", A_PCG, rca_pkg::RST_PCG0);
		rdchk("ssm_rst", A_OSM, rca_pkg::RST_SSM);
		rdchk("ctl0_rst", A_C0, rca_pkg::RST_CTL0);
		rdchk("ctl1_rst", A_C1, rca_pkg::RST_CTL1);
		rdchk("unmapped", 20'hFFF00, 8'h00);
		// gate still off: control writes vanish, supply mode does not
		wr(A_C0, 8'h2F);
		rdchk("ctl0_gated", A_C0, 8'h00);
		wr(A_OSM, 8'h10);
		rdchk("ssm_gated", A_OSM, 8'h10);
		wr(A_PCG, 8'h80);
		rdchk("pcg0_rw", A_PCG, 8'h80);
		// random control values with run and hour format left clear
		for (int i = 0; i < 6; i++) begin
			r = xs();
			v = r[7:0];
			wr(A_C0, v & 8'h77);
			rdchk("ctl0_rw", A_C0, ctl0_exp(v & 8'h77));
			wr(A_OSM, v);
			rdchk("ssm_rw", A_OSM, ssm_exp(v));
		end
		// low-speed source, half-second period, 1 Hz output off
		wr(A_OSM, 8'h10);
		wr(A_C0, 8'h01);
		ls_on = 1'b1;
		wr(A_C0, 8'h81);
		wait_irq(HALF_CYC + 200, n);
		`CHK("ls_half", 1'b1, (n >= HALF_CYC - 16) && (n <= HALF_CYC + 16));
		idle(8);
		`CHK("hz_disabled", 1'b0, one_hz_pin);
		rdchk("pflag_set", A_C1, 8'h08);
		wr(A_C1, 8'h08);
		rdchk("pflag_keep", A_C1, 8'h08);
		wr(A_C1, 8'h00);
		rdchk("pflag_clr", A_C1, 8'h00);
		// gate off after run and source stop must wipe the control state
		wr(A_C0, 8'h01);
		ls_on = 1'b0;
		wr(A_PCG, 8'h00);
		rdchk("ctl0_off", A_C0, 8'h00);
		rdchk("ssm_kept", A_OSM, 8'h10);
		wr(A_PCG, 8'h80);
		rdchk("ctl0_cleared", A_C0, 8'h00);
		// subsystem source, 1 Hz enabled before the run starts
		wr(A_OSM, 8'h00);
		sub_on = 1'b1;
		wr(A_C0, 8'h21);
		idle(20);
		`CHK("hz_stopped", 1'b0, one_hz_pin);
		wr(A_C0, 8'hA1);
		wait_irq(HALF_CYC + 200, n);
		`CHK("sub_half", 1'b1, (n >= HALF_CYC - 16) && (n <= HALF_CYC + 16));
		idle(8);
		`CHK("hz_on", 1'b1, one_hz_pin);
		wr(A_C0, 8'hA0);
		wr(A_C1, 8'h00);
		// alarm: matching off, then on with and without interrupt
		wr(A_C1, 8'h40);
		alarm_minute = 6'h00;
		idle(20);
		rdchk("alarm_off", A_C1, 8'h40);
		wr(A_C1, 8'hC0);
		wait_irq(40, n);
		`CHK("alarm_irq", 1'b1, n < 40);
		rdchk("alarm_flag", A_C1, 8'hD0);
		wr(A_C1, 8'h80);
		r = xs();
		alarm_minute = 6'(1 + r % 59);
		idle(10);
		alarm_minute = 6'h00;
		wait_irq(40, n);
		`CHK("alarm_quiet", 32'd40, n);
		rdchk("alarm_flag2", A_C1, 8'h90);
		// counter wait, then hour format both ways
		wr(A_C1, 8'h91);
		idle(20);
		rdchk("wait_st", A_C1, 8'h93);
		wr(A_C0, 8'hA8);
		idle(20);
		`CHK("hour_24", 8'h00, hour_value);
		wr(A_C0, 8'hA0);
		idle(20);
		`CHK("hour_12", 8'h12, hour_value);
		wr(A_C1, 8'h80);
		rdchk("wait_rel", A_C1, 8'h80);
		end_of_test();
	end
endmodule // rca_block_tb_top
`default_nettype wire
